/* File: inc/bwsc_pkg.sv */
// Purpose: Shared constants and types for the bus wait-state configuration block
// Assumes: 21-bit byte address, 16-bit core data bus
// Notes: Register offsets are the core-bus byte addresses of the four registers
package bwsc_pkg;

  // Register addresses
  localparam logic [20:0] WMC_ADDR = 21'h00f900;
  localparam logic [20:0] IOZ_ADDR = 21'h00f902;
  localparam logic [20:0] FLZ_ADDR = 21'h00f904;
  localparam logic [20:0] BRZ_ADDR = 21'h00f906;

  // Reset values
  localparam logic [7:0] WMC_RESET = 8'h07;
  localparam logic [15:0] ZONE_RESET = 16'h069f;

  // Write-mode register fields
  localparam int WMC_EWR_BIT = 0;
  localparam logic [7:0] WMC_WRITE_MASK = 8'h07;

  // Zone register field positions
  localparam int ZF_WAIT_LSB = 0;
  localparam int ZF_HOLD_LSB = 3;
  localparam int ZF_BW_BIT = 7;
  localparam int ZF_POST_IDLE_ENABLE_BIT = 10;
  localparam int ZF_PRELIMINARY_IDLE_ENABLE_BIT = 11;
  localparam int ZF_FRE_BIT = 12;
  // Writable bits; the I/O zone has no fast-read or preliminary-idle bits
  localparam logic [15:0] IOZ_WRITE_MASK = 16'h049f;
  localparam logic [15:0] SZ_WRITE_MASK = 16'h1c9f;

  // Address ranges
  localparam logic [20:0] FLASH_LO_END = 21'h00bfff;
  localparam logic [20:0] FLASH_HI_BEG = 21'h01c000;
  localparam logic [20:0] FLASH_HI_END = 21'h01ffff;
  localparam logic [20:0] RAM_BEG = 21'h00c000;
  localparam logic [20:0] RAM_END = 21'h00cbff;
  localparam logic [20:0] EE_BEG = 21'h00f000;
  localparam logic [20:0] EE_END = 21'h00f27f;
  localparam logic [20:0] PER_A_BEG = 21'h00f800;
  localparam logic [20:0] PER_A_END = 21'h00faff;
  localparam logic [20:0] IOP_BEG = 21'h00fb00;
  localparam logic [20:0] IOP_END = 21'h00fb16;
  localparam logic [20:0] PER_B_BEG = 21'h00fc00;
  localparam logic [20:0] PER_B_END = 21'h00ffff;
  localparam logic [20:0] BOOT_BEG = 21'h00e000;
  localparam logic [20:0] BOOT_END = 21'h00e5ff;

  // Fixed timings
  localparam logic [3:0] PER_WAIT = 4'h1;

  // Zone identifiers, one-hot
  typedef enum logic [5:0] {
    BWSC_Z_NONE = 6'h01,
    BWSC_Z_FLASH = 6'h02,
    BWSC_Z_BOOT = 6'h04,
    BWSC_Z_IO = 6'h08,
    BWSC_Z_RAM = 6'h10,
    BWSC_Z_PER = 6'h20
  } bwsc_zone_e;

  // Cycle plan for one access
  typedef struct packed {
    logic [3:0] wait_n;
    logic [1:0] hold_n;
    logic pre_idle;
    logic post_idle;
    logic single;
  } bwsc_plan_s;

  // Core request
  typedef struct packed {
    logic [20:0] addr;
    logic write;
    logic [15:0] wdata;
  } bwsc_req_s;

endpackage : bwsc_pkg

/* File: rtl/bwsc_regs.sv */
// Purpose: Four timing configuration registers on the core bus
// Assumes: Word writes with byte enables, one-cycle register access
// Notes: Read data is registered
module bwsc_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register access
  input wire logic sel,
  input wire logic write,
  input wire logic [20:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] byte_en,
  output logic [15:0] rdata_q,
  output logic hit,
  // Configuration out
  output logic [7:0] write_mode_config_q,
  output logic [15:0] io_zone_timing_config_q,
  output logic [15:0] flash_zone_timing_config_q,
  output logic [15:0] bootrom_zone_timing_config_q
);

  logic hit_wm, hit_io, hit_fl, hit_br;
  logic [15:0] be_mask;

  // Address decode
  always_comb begin
    hit_wm = 1'b0;
    hit_io = 1'b0;
    hit_fl = 1'b0;
    hit_br = 1'b0;
    if (addr[20:1] == bwsc_pkg::WMC_ADDR[20:1]) begin
      hit_wm = 1'b1;
    end else if (addr[20:1] == bwsc_pkg::IOZ_ADDR[20:1]) begin
      hit_io = 1'b1;
    end else if (addr[20:1] == bwsc_pkg::FLZ_ADDR[20:1]) begin
      hit_fl = 1'b1;
    end else if (addr[20:1] == bwsc_pkg::BRZ_ADDR[20:1]) begin
      hit_br = 1'b1;
    end
  end
  assign hit = hit_wm | hit_io | hit_fl | hit_br;
  assign be_mask = {{8{byte_en[1]}}, {8{byte_en[0]}}};

  // Write-mode register, byte wide; upper byte lane ignored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      write_mode_config_q <= bwsc_pkg::WMC_RESET;
    end else if (sel && write && hit_wm && byte_en[0]) begin
      // Reserved bits held at zero whatever software writes
      write_mode_config_q <= wdata[7:0] & bwsc_pkg::WMC_WRITE_MASK;
    end
  end

  // Zone registers; bits software cannot set are cleared by any write to their byte lane
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      io_zone_timing_config_q <= bwsc_pkg::ZONE_RESET;
      flash_zone_timing_config_q <= bwsc_pkg::ZONE_RESET;
      bootrom_zone_timing_config_q <= bwsc_pkg::ZONE_RESET;
    end else if (sel && write) begin
      if (hit_io) begin
        io_zone_timing_config_q <= (io_zone_timing_config_q & ~be_mask)
          | (wdata & be_mask & bwsc_pkg::IOZ_WRITE_MASK);
      end
      if (hit_fl) begin
        flash_zone_timing_config_q <= (flash_zone_timing_config_q & ~be_mask)
          | (wdata & be_mask & bwsc_pkg::SZ_WRITE_MASK);
      end
      if (hit_br) begin
        bootrom_zone_timing_config_q <= (bootrom_zone_timing_config_q & ~be_mask)
          | (wdata & be_mask & bwsc_pkg::SZ_WRITE_MASK);
      end
    end
  end

  // Read data register; unmapped reads return zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (sel && !write) begin
      if (hit_wm) begin
        rdata_q <= {8'h00, write_mode_config_q};
      end else if (hit_io) begin
        rdata_q <= io_zone_timing_config_q;
      end else if (hit_fl) begin
        rdata_q <= flash_zone_timing_config_q;
      end else if (hit_br) begin
        rdata_q <= bootrom_zone_timing_config_q;
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

endmodule // bwsc_regs

/* File: rtl/bwsc_plan.sv */
// Purpose: Turn address, direction and settings into a cycle plan
// Assumes: Combinational, evaluated in the request cycle
// Notes: wait_n counts extra cycles after the address cycle
module bwsc_plan (
  // Request
  input wire logic [20:0] addr,
  input wire logic write,
  // Settings
  input wire logic [7:0] wmc,
  input wire logic [15:0] ioz,
  input wire logic [15:0] flz,
  input wire logic [15:0] brz,
  input wire logic eeprom_no_wait_select,
  // Result
  output bwsc_pkg::bwsc_zone_e zone,
  output bwsc_pkg::bwsc_plan_s plan
);

  logic early_write_select, fre0;
  // Zone 0 fast read masks wait and hold of both static zones
  logic mask_wh;
  logic [3:0] wfield;
  logic [15:0] zc;

  assign early_write_select = wmc[bwsc_pkg::WMC_EWR_BIT];
  assign fre0 = flz[bwsc_pkg::ZF_FRE_BIT];
  assign mask_wh = fre0 && (zone != bwsc_pkg::BWSC_Z_IO);

  // Zone decode
  always_comb begin
    zone = bwsc_pkg::BWSC_Z_NONE;
    if (addr <= bwsc_pkg::FLASH_LO_END || (addr >= bwsc_pkg::FLASH_HI_BEG
        && addr <= bwsc_pkg::FLASH_HI_END)) begin
      zone = bwsc_pkg::BWSC_Z_FLASH;
    end else if (addr >= bwsc_pkg::RAM_BEG && addr <= bwsc_pkg::RAM_END) begin
      zone = bwsc_pkg::BWSC_Z_RAM;
    end else if (addr >= bwsc_pkg::BOOT_BEG && addr <= bwsc_pkg::BOOT_END) begin
      zone = bwsc_pkg::BWSC_Z_BOOT;
    end else if (addr >= bwsc_pkg::IOP_BEG && addr <= bwsc_pkg::IOP_END) begin
      zone = bwsc_pkg::BWSC_Z_IO;
    end else if ((addr >= bwsc_pkg::PER_A_BEG && addr <= bwsc_pkg::PER_A_END)
        || (addr >= bwsc_pkg::PER_B_BEG && addr <= bwsc_pkg::PER_B_END)
        || (addr >= bwsc_pkg::EE_BEG && addr <= bwsc_pkg::EE_END)) begin
      zone = bwsc_pkg::BWSC_Z_PER;
    end
  end

  // Zone settings selection
  always_comb begin
    zc = 16'h0000;
    if (zone == bwsc_pkg::BWSC_Z_FLASH) begin
      zc = flz;
    end else if (zone == bwsc_pkg::BWSC_Z_BOOT) begin
      zc = brz;
    end else if (zone == bwsc_pkg::BWSC_Z_IO) begin
      zc = ioz;
    end
  end
  assign wfield = {1'b0, zc[bwsc_pkg::ZF_WAIT_LSB +: 3]};

  // Cycle plan
  always_comb begin
    plan = '0;
    if (zone == bwsc_pkg::BWSC_Z_RAM) begin
      plan.single = 1'b1;
    end else if (zone == bwsc_pkg::BWSC_Z_PER) begin
      if (addr >= bwsc_pkg::EE_BEG && addr <= bwsc_pkg::EE_END) begin
        plan.single = eeprom_no_wait_select;
        plan.wait_n = eeprom_no_wait_select ? 4'h0 : 4'h1;
      end else begin
        plan.wait_n = bwsc_pkg::PER_WAIT;
        plan.pre_idle = 1'b1;
      end
    end else if (zone == bwsc_pkg::BWSC_Z_NONE) begin
      plan.single = 1'b1;
    end else if (zc[bwsc_pkg::ZF_FRE_BIT] && zone != bwsc_pkg::BWSC_Z_IO) begin
      // Zone's own fast read: one-cycle reads, writes take one wait
      plan.single = !write;
      plan.wait_n = write ? 4'h1 : 4'h0;
      plan.pre_idle = zc[bwsc_pkg::ZF_PRELIMINARY_IDLE_ENABLE_BIT];
      plan.post_idle = zc[bwsc_pkg::ZF_POST_IDLE_ENABLE_BIT];
    end else begin
      // Normal read one extra wait; write one more in early mode
      plan.wait_n = (mask_wh ? 4'h0 : wfield) + 4'h1
        + ((write && early_write_select) ? 4'h1 : 4'h0);
      plan.hold_n = mask_wh ? 2'h0 : zc[bwsc_pkg::ZF_HOLD_LSB +: 2];
      plan.pre_idle = (zone != bwsc_pkg::BWSC_Z_IO) && zc[bwsc_pkg::ZF_PRELIMINARY_IDLE_ENABLE_BIT];
      plan.post_idle = zc[bwsc_pkg::ZF_POST_IDLE_ENABLE_BIT];
    end
  end

endmodule // bwsc_plan

/* File: rtl/bus_wait_state_config.sv */
// Purpose: Core-bus wait, hold and idle cycle sequencer with its config registers
// Assumes: Single 10 MHz clock; CPU holds request until ready
// Notes: Memory responds combinationally to mem_sel within the data phase
module bus_wait_state_config (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // CPU request
  input wire logic req_valid,
  input wire bwsc_pkg::bwsc_req_s req,
  input wire logic [1:0] req_byte_en,
  output logic req_ready,
  output logic [15:0] rsp_rdata_q,
  // Module configuration input
  input wire logic eeprom_no_wait_select,
  // Memory side
  output logic mem_sel,
  output logic mem_write,
  output logic [20:0] mem_addr_q,
  output logic [15:0] mem_wdata_q,
  output logic mem_hold,
  input wire logic [15:0] mem_rdata,
  // Zone settings seen by memories
  output logic [1:0] zone_bus_width
);

  // State machine, one-hot
  typedef enum logic [5:0] {
    BWSC_S_IDLE = 6'h01,
    BWSC_S_PRE = 6'h02,
    BWSC_S_ADDR = 6'h04,
    BWSC_S_WAIT = 6'h08,
    BWSC_S_HOLD = 6'h10,
    BWSC_S_POST = 6'h20
  } bwsc_state_e;

  bwsc_state_e state_q, state_d;
  bwsc_pkg::bwsc_zone_e zone, last_zone_q, cur_zone_q;
  bwsc_pkg::bwsc_plan_s plan, plan_q;
  logic [7:0] write_mode_config_q;
  logic [15:0] io_zone_timing_config_q;
  logic [15:0] flash_zone_timing_config_q;
  logic [15:0] bootrom_zone_timing_config_q;
  logic reg_hit;
  logic [15:0] reg_rdata_q;
  logic [3:0] wait_cnt_q;
  logic [1:0] hold_cnt_q;
  logic is_reg_q;
  logic post_pend_q;
  logic accept;
  logic zone_change;
  logic finish;
  logic [15:0] rdata_mux;
  logic wr_q; // Direction of the latched access

  // Configuration registers
  bwsc_regs u_regs (
    .clk(clk),
    .reset(reset),
    .sel(accept),
    .write(req.write),
    .addr(req.addr),
    .wdata(req.wdata),
    .byte_en(req_byte_en),
    .rdata_q(reg_rdata_q),
    .hit(reg_hit),
    .write_mode_config_q(write_mode_config_q),
    .io_zone_timing_config_q(io_zone_timing_config_q),
    .flash_zone_timing_config_q(flash_zone_timing_config_q),
    .bootrom_zone_timing_config_q(bootrom_zone_timing_config_q)
  );

  // Per-access cycle planner
  bwsc_plan u_plan (
    .addr(req.addr),
    .write(req.write),
    .wmc(write_mode_config_q),
    .ioz(io_zone_timing_config_q),
    .flz(flash_zone_timing_config_q),
    .brz(bootrom_zone_timing_config_q),
    .eeprom_no_wait_select(eeprom_no_wait_select),
    .zone(zone),
    .plan(plan)
  );

  // Width bits reported for flash and boot zones; software keeps them at 16
  assign zone_bus_width = {bootrom_zone_timing_config_q[bwsc_pkg::ZF_BW_BIT],
    flash_zone_timing_config_q[bwsc_pkg::ZF_BW_BIT]};

  // Zone change against the last access
  assign zone_change = (zone != last_zone_q);

  // A request is taken only in the address cycle
  assign accept = (state_q == BWSC_S_ADDR);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      BWSC_S_IDLE: begin
        if (req_valid) begin
          if (plan.pre_idle && zone_change) begin
            state_d = BWSC_S_PRE;
          end else begin
            state_d = BWSC_S_ADDR;
          end
        end
      end
      BWSC_S_PRE: begin
        state_d = BWSC_S_ADDR;
      end
      BWSC_S_ADDR: begin
        // Waits come right after the address cycle
        if (plan_q.wait_n != 4'h0) begin
          state_d = BWSC_S_WAIT;
        end else if (plan_q.hold_n != 2'h0) begin
          state_d = BWSC_S_HOLD;
        end else begin
          state_d = BWSC_S_IDLE;
        end
      end
      BWSC_S_WAIT: begin
        if (wait_cnt_q == 4'h1) begin
          state_d = (plan_q.hold_n != 2'h0) ? BWSC_S_HOLD : BWSC_S_IDLE;
        end
      end
      BWSC_S_HOLD: begin
        if (hold_cnt_q == 2'h1) begin
          state_d = BWSC_S_IDLE;
        end
      end
      BWSC_S_POST: begin
        state_d = BWSC_S_ADDR;
      end
      default: begin
        state_d = BWSC_S_IDLE;
      end
    endcase
    // Post-idle: next access to a new zone waits one idle cycle
    if (state_q == BWSC_S_IDLE && req_valid && post_pend_q && zone_change) begin
      state_d = BWSC_S_POST;
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= BWSC_S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Plan and zone are latched on leaving idle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      plan_q <= '0;
      cur_zone_q <= bwsc_pkg::BWSC_Z_NONE;
      mem_addr_q <= 21'h000000;
      mem_wdata_q <= 16'h0000;
    end else if (state_q == BWSC_S_IDLE && req_valid) begin
      plan_q <= plan;
      cur_zone_q <= zone;
      mem_addr_q <= req.addr;
      mem_wdata_q <= req.wdata;
    end
  end

  // Remembers the zone of the previous access
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_zone_q <= bwsc_pkg::BWSC_Z_NONE;
      post_pend_q <= 1'b0;
    end else if (finish) begin
      last_zone_q <= cur_zone_q;
      post_pend_q <= plan_q.post_idle;
    end
  end

  // Wait counter, loaded at the end of the address cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_cnt_q <= 4'h0;
    end else if (state_q == BWSC_S_ADDR) begin
      wait_cnt_q <= plan_q.wait_n;
    end else if (state_q == BWSC_S_WAIT) begin
      wait_cnt_q <= wait_cnt_q - 4'h1;
    end
  end

  // Hold counter; holds sit at the end of the cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_cnt_q <= 2'h0;
    end else if (state_d == BWSC_S_HOLD && state_q != BWSC_S_HOLD) begin
      hold_cnt_q <= plan_q.hold_n;
    end else if (state_q == BWSC_S_HOLD) begin
      hold_cnt_q <= hold_cnt_q - 2'h1;
    end
  end

  // Is the current access to a configuration register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      is_reg_q <= 1'b0;
    end else if (state_q == BWSC_S_IDLE && req_valid) begin
      is_reg_q <= reg_hit;
    end
  end

  // Access ends when the sequencer returns to idle
  assign finish = (state_q != BWSC_S_IDLE) && (state_d == BWSC_S_IDLE);
  assign req_ready = finish;

  // Memory strobes: select through address, waits and holds
  assign mem_sel = (state_q == BWSC_S_ADDR) || (state_q == BWSC_S_WAIT)
    || (state_q == BWSC_S_HOLD);
  assign mem_write = mem_sel && plan_is_write();
  assign mem_hold = (state_q == BWSC_S_HOLD);

  // Direction of the latched access
  function automatic logic plan_is_write();
    return wr_q;
  endfunction

  // Direction register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q <= 1'b0;
    end else if (state_q == BWSC_S_IDLE && req_valid) begin
      wr_q <= req.write;
    end
  end

  // Read data source; registers answer a cycle later so use their flop
  assign rdata_mux = is_reg_q ? reg_rdata_q : mem_rdata;

  // Read data captured for the CPU at the end of each read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_rdata_q <= 16'h0000;
    end else if (state_q != BWSC_S_IDLE && !wr_q && !is_reg_q && mem_sel) begin
      rsp_rdata_q <= rdata_mux;
    end else if (is_reg_q && state_q == BWSC_S_WAIT) begin
      rsp_rdata_q <= rdata_mux;
    end
  end

endmodule // bus_wait_state_config

/* File: verification/bwsc_sva.sv */
// Purpose: Port-level timing checks for the wait-state sequencer
// Assumes: One clock domain, async active-high reset
// Notes: Decodes use the latched address, valid from the address cycle on
module bwsc_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Core side
  input wire logic req_valid,
  input wire bwsc_pkg::bwsc_req_s req,
  input wire logic req_ready,
  input wire logic eeprom_no_wait_select,
  // Memory side
  input wire logic mem_sel,
  input wire logic mem_write,
  input wire logic [20:0] mem_addr_q,
  input wire logic mem_hold,
  input wire logic [1:0] zone_bus_width
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Range decodes
  logic in_ram;
  logic in_ee;
  logic in_per;
  assign in_ram = mem_addr_q >= bwsc_pkg::RAM_BEG && mem_addr_q <= bwsc_pkg::RAM_END;
  assign in_ee = mem_addr_q >= bwsc_pkg::EE_BEG && mem_addr_q <= bwsc_pkg::EE_END;
  // Registers sit in the first peripheral window, so they are checked too
  assign in_per = (mem_addr_q >= bwsc_pkg::PER_A_BEG && mem_addr_q <= bwsc_pkg::PER_A_END)
    || (mem_addr_q >= bwsc_pkg::PER_B_BEG && mem_addr_q <= bwsc_pkg::PER_B_END);
  property p_ram_single;
    $rose(mem_sel) && in_ram |-> req_ready;
  endproperty
  a_ram_single: assert property (p_ram_single) else $error("RAM access not single cycle");
  property p_ee_wait;
    $rose(mem_sel) && in_ee |-> if (eeprom_no_wait_select) req_ready
      else (!req_ready ##1 req_ready);
  endproperty
  a_ee_wait: assert property (p_ee_wait) else $error("EEPROM wait count wrong");
  property p_no_hold;
    mem_sel && (in_ee || in_per) |-> !mem_hold;
  endproperty
  a_no_hold: assert property (p_no_hold) else $error("Hold seen on fixed zone");
  property p_per_wait;
    $rose(mem_sel) && in_per |-> !req_ready ##1 req_ready;
  endproperty
  a_per_wait: assert property (p_per_wait) else $error("Peripheral wait wrong");
  property p_hold_end;
    mem_hold && !req_ready |=> mem_hold;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("Hold not at end of access");
  property p_hold_sel;
    mem_hold |-> mem_sel && !$rose(mem_sel);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("Hold outside data phase");
  property p_write_dir;
    mem_sel && req_valid |-> mem_write == req.write;
  endproperty
  a_write_dir: assert property (p_write_dir) else $error("Write strobe mismatch");
  property p_addr_stable;
    mem_sel && !req_ready |=> mem_sel && $stable(mem_addr_q);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("Address moved mid access");
  property p_bound;
    $rose(mem_sel) |-> ##[0:12] req_ready;
  endproperty
  a_bound: assert property (p_bound) else $error("Access longer than allowed");
  property p_width;
    $fell(reset) |-> zone_bus_width == 2'h3;
  endproperty
  a_width: assert property (p_width) else $error("Bus width not 16 after reset");
endmodule // bwsc_sva

bind bus_wait_state_config bwsc_sva i_sva (.clk(clk), .reset(reset), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .eeprom_no_wait_select(eeprom_no_wait_select),
  .mem_sel(mem_sel), .mem_write(mem_write), .mem_addr_q(mem_addr_q), .mem_hold(mem_hold),
  .zone_bus_width(zone_bus_width));

/* File: verification/bwsc_mem_model.sv */
// Purpose: On-chip memory stand-in answering the data phase
// Assumes: Data is a fixed function of the latched address
// Notes: Unselected, the bus shows the inverse of the last word
module bwsc_mem_model (
  // Clock
  input wire logic clk,
  // Block memory side
  input wire logic mem_sel,
  input wire logic [20:0] mem_addr_q,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Last word driven, so a stale sample cannot look right
  logic [15:0] last_q = 16'h0000;
  // Track the word on the bus while selected
  always_ff @(posedge clk) begin
    if (mem_sel) begin
      last_q <= mem_rdata;
    end
  end
  assign mem_rdata = mem_sel ? (mem_addr_q[15:0] ^ 16'h5a5a) : ~last_q;
endmodule // bwsc_mem_model

/* File: verification/bus_wait_state_config_bench.sv */
// Purpose: Self-checking bench for access timing and registers
// Assumes: Inputs change on the falling edge, one request at a time
// Notes: Expected cycle counts come from a bench model of the settings
module bus_wait_state_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  bwsc_pkg::bwsc_req_s req = '0;
  logic [1:0] req_byte_en = 2'h3;
  logic nows = 1'b0;
  // Observed
  logic req_ready, mem_sel, mem_write, mem_hold;
  logic [15:0] rsp_rdata_q, mem_wdata_q, mem_rdata;
  logic [20:0] mem_addr_q;
  logic [1:0] zone_bus_width;
  // Bench copy of the settings and the last zone
  logic [7:0] wmc = 8'h07;
  logic [15:0] flz = 16'h069f, brz = 16'h069f, ioz = 16'h069f;
  int prev_z = 0;
  logic prev_post = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  bus_wait_state_config i_dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
    .req_byte_en(req_byte_en), .req_ready(req_ready), .rsp_rdata_q(rsp_rdata_q),
    .eeprom_no_wait_select(nows), .mem_sel(mem_sel), .mem_write(mem_write),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_hold(mem_hold),
    .mem_rdata(mem_rdata), .zone_bus_width(zone_bus_width));
  bwsc_mem_model i_mem (.clk(clk), .mem_sel(mem_sel), .mem_addr_q(mem_addr_q),
    .mem_rdata(mem_rdata));
  // 100 ns clock
  always #50 clk = ~clk;
  // Hang guard, about ten times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // Verdict
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Single comparison point
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // Zone code: 1 flash, 2 boot, 3 io, 4 ram, 5 fixed peripheral
  function automatic int zone_of(logic [20:0] a);
    if (a <= bwsc_pkg::FLASH_LO_END || a >= bwsc_pkg::FLASH_HI_BEG) return 1;
    if (a >= bwsc_pkg::BOOT_BEG && a <= bwsc_pkg::BOOT_END) return 2;
    if (a >= bwsc_pkg::IOP_BEG && a <= bwsc_pkg::IOP_END) return 3;
    if (a >= bwsc_pkg::RAM_BEG && a <= bwsc_pkg::RAM_END) return 4;
    if (a >= bwsc_pkg::EE_BEG) return 5;
    return 0;
  endfunction
  // Cycles from the taking edge to the ready cycle
  function automatic int exp_n(logic [20:0] a, logic wr);
    int z;
    int n;
    logic [15:0] c;
    logic pre;
    z = zone_of(a);
    c = (z == 2) ? brz : ((z == 3) ? ioz : flz);
    if (z == 4) return 1;
    // Fixed zone: EEPROM by its select, peripherals one wait
    if (z == 5) n = (a <= bwsc_pkg::EE_END && nows) ? 1 : 2;
    // Zone 0 fast read masks wait and hold of both static zones
    else if (c[12]) n = wr ? 2 : 1;
    else n = 2 + ((flz[12] && z != 3) ? 0 : c[2:0] + c[4:3]) + (wr ? wmc[0] : 1'b0);
    pre = (z == 5) ? (a > bwsc_pkg::EE_END) : c[11];
    // A pending post-idle counts on any zone change
    if (z != prev_z && (pre || prev_post)) n++;
    return n;
  endfunction
  // One core access; optionally checks its length
  task automatic acc(input logic [20:0] a, input logic wr, input logic [15:0] d,
      input logic ck, output logic [15:0] rd);
    int n;
    int e;
    int z;
    e = exp_n(a, wr);
    z = zone_of(a);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{addr: a, write: wr, wdata: d};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    @(negedge clk);
    req_valid = 1'b0;
    rd = rsp_rdata_q;
    if (ck) chk(16'(n), 16'(e));
    if (wr) chk(mem_wdata_q, d);
    prev_z = z;
    prev_post = (z == 1) ? flz[10] : ((z == 2) ? brz[10] : ((z == 3) ? ioz[10] : 1'b0));
  endtask
  // Register write, keeping the bench copy; callers write reserved bits as zero
  task automatic cfg(input logic [20:0] a, input logic [15:0] v);
    logic [15:0] rd;
    acc(a, 1'b1, v, 1'b0, rd);
    if (a == bwsc_pkg::WMC_ADDR) wmc = v[7:0];
    if (a == bwsc_pkg::IOZ_ADDR) ioz = v;
    if (a == bwsc_pkg::FLZ_ADDR) flz = v;
    if (a == bwsc_pkg::BRZ_ADDR) brz = v;
  endtask
  // Memory access with read data check
  task automatic op(input logic [20:0] a, input logic wr);
    logic [15:0] rd;
    acc(a, wr, 16'($urandom), 1'b1, rd);
    if (!wr && zone_of(a) != 5) chk(rd, a[15:0] ^ 16'h5a5a);
  endtask
  // Random zone setting: width 16, wait and hold random
  function automatic logic [15:0] rnd_zone();
    return 16'h0080 | (16'($urandom) & 16'h001f);
  endfunction
  initial begin
    logic [15:0] rd;
    logic [20:0] a;
    void'($urandom(32'hbe95d939));
    repeat (10) @(negedge clk);
    reset = 1'b0;
    // Reset values of the four registers
    for (int i = 0; i < 4; i++) begin
      acc(21'h00f900 + 21'(2 * i), 1'b0, 16'h0000, 1'b0, rd);
      chk(rd, (i == 0) ? 16'h0007 : 16'h069f);
    end
    cfg(bwsc_pkg::WMC_ADDR, 16'h0006);
    acc(bwsc_pkg::WMC_ADDR, 1'b0, 16'h0000, 1'b0, rd);
    chk(rd, 16'h0006);
    // Random settings, every zone in turn
    for (int i = 0; i < 24; i++) begin
      cfg(bwsc_pkg::FLZ_ADDR, rnd_zone());
      cfg(bwsc_pkg::BRZ_ADDR, rnd_zone());
      cfg(bwsc_pkg::IOZ_ADDR, rnd_zone());
      cfg(bwsc_pkg::WMC_ADDR, $urandom_range(1) ? 16'h0007 : 16'h0006);
      acc(bwsc_pkg::FLZ_ADDR, 1'b0, 16'h0000, 1'b0, rd);
      chk(rd, flz);
      chk(16'(zone_bus_width), {14'h0000, brz[7], flz[7]});
      nows = 1'($urandom);
      a = $urandom_range(1) ? 21'h01c000 | (21'($urandom) & 21'h003ffe)
        : 21'($urandom) & 21'h007ffe;
      op(a, 1'b0);
      op(a, 1'b1);
      op(21'h00e000 | (21'($urandom) & 21'h0005fe), 1'b0);
      op(21'h00fb00 | (21'($urandom) & 21'h000016), 1'($urandom));
      op(21'h00c000 | (21'($urandom) & 21'h0007fe), 1'b1);
      op(21'h00f800 | (21'($urandom) & 21'h0000fe), 1'b0);
      op(21'h00f000 | (21'($urandom) & 21'h00027e), 1'b0);
      op(21'h00c000 | (21'($urandom) & 21'h0007fe), 1'b0);
      op(21'h00fc00 | (21'($urandom) & 21'h0003fe), 1'b1);
    end
    // Fast read with slow fields at the range edges
    cfg(bwsc_pkg::FLZ_ADDR, 16'h109f);
    cfg(bwsc_pkg::BRZ_ADDR, 16'h009f);
    op(21'h00bffe, 1'b0);
    op(21'h01fffe, 1'b1);
    op(21'h00e000, 1'b0);
    // Preliminary idle only on a zone change
    cfg(bwsc_pkg::FLZ_ADDR, 16'h0882);
    op(21'h00c000, 1'b0);
    op(21'h000000, 1'b0);
    op(21'h000002, 1'b0);
    // Post idle before a boot access
    cfg(bwsc_pkg::FLZ_ADDR, 16'h0480);
    cfg(bwsc_pkg::BRZ_ADDR, 16'h0080);
    op(21'h000004, 1'b0);
    op(21'h00e002, 1'b0);
    op(21'h00e004, 1'b0);
    // Longest write: early write, wait and hold fields at maximum
    cfg(bwsc_pkg::WMC_ADDR, 16'h0007);
    cfg(bwsc_pkg::FLZ_ADDR, 16'h009f);
    op(21'h000006, 1'b1);
    tally_and_finish();
  end
endmodule // bus_wait_state_config_bench
